// File: pkg/sdp_pkg.sv
// package of constants and carrier types for the serial datagram port
package sdp_pkg;
  // datagram geometry
  localparam int unsigned SDP_DG_BITS = 40;
  localparam int unsigned SDP_DATA_BITS = 32;
  localparam int unsigned SDP_ADDR_BITS = 7;
  localparam int unsigned SDP_STAT_BITS = 8;
  localparam int unsigned SDP_RW_POS = 39;
  localparam int unsigned SDP_ADDR_MSB = 38;
  localparam int unsigned SDP_ADDR_LSB = 32;
  localparam int unsigned SDP_CNT_BITS = 6;
  localparam logic [5:0] SDP_CNT_FULL = 6'h28;
  // buffer depth
  localparam int unsigned SDP_BUF_DEPTH = 2;
  // reset values
  localparam logic [31:0] SDP_DATA_RST = 32'h00000000;
  localparam logic [39:0] SDP_SR_RST = 40'h0000000000;

  // command handed to the register file
  typedef struct packed {
    logic write;
    logic [6:0] addr;
    logic [31:0] data;
  } sdp_cmd_t;
endpackage

// File: hdl/sdp_cmd_buf.sv
// two-entry valid/ready buffer for commands
`timescale 1ns/10ps
`default_nettype none
module sdp_cmd_buf
  import sdp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire sdp_cmd_t in_data,
  output logic out_valid,
  input wire logic out_ready,
  output sdp_cmd_t out_data
);
  // storage in flip-flops, indexed by pointer
  sdp_cmd_t mem_q [SDP_BUF_DEPTH];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_ptr_q];

  // pointers and fill count
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= ~wr_ptr_q;
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // data entries, no reset needed but kept defined
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end
    else if (push)
      mem_q[wr_ptr_q] <= in_data;
  end
endmodule
`default_nettype wire

// File: hdl/sdp_port.sv
// serial slave datagram port: shifter, command latch and reply pipe
`timescale 1ns/10ps
`default_nettype none
module sdp_port
  import sdp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  // serial pins from the host
  input wire logic host_select_n,
  input wire logic host_serial_clock,
  input wire logic host_serial_in,
  output logic host_serial_out,
  // user-selected event bits for the status byte
  input wire logic [7:0] status_events,
  // command stream to the register file
  output logic cmd_valid,
  input wire logic cmd_ready,
  output sdp_cmd_t cmd_out,
  // register file reply for the pending read
  input wire logic [31:0] read_data,
  input wire logic read_data_valid,
  // high when a command was dropped for a full buffer
  output logic cmd_overrun,
  // pulse when a short transfer was discarded
  output logic short_frame
);
  // synchroniser stages; stage one read only by stage two
  logic sck_s1_q, sck_s2_q;
  logic sck_s3_q;
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic sdi_s1_q, sdi_s2_q;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
    end
    else
    begin
      sck_s1_q <= host_serial_clock;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      cs_s1_q <= host_select_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      sdi_s1_q <= host_serial_in;
      sdi_s2_q <= sdi_s1_q;
    end
  end

  // edge events in the system domain, one cycle each, and the select level sel_act
  wire sck_rise = sck_s2_q && !sck_s3_q;
  wire sck_fall = !sck_s2_q && sck_s3_q;
  wire cs_fall = !cs_s2_q && cs_s3_q;
  wire cs_rise = cs_s2_q && !cs_s3_q;
  wire sel_act = !cs_s2_q;

  // shifter state
  logic [39:0] sr_q, sr_d;
  logic [5:0] cnt_q, cnt_d;
  logic [39:0] tx_q, tx_d;
  logic sdo_q, sdo_d;
  logic [31:0] reply_q, reply_d;
  logic ovr_q;
  logic short_q;

  // bit counter saturates at 40: only "enough" matters
  wire cnt_full = (cnt_q == SDP_CNT_FULL);
  wire frame_ok = cs_rise && cnt_full;
  wire frame_short = cs_rise && !cnt_full;

  sdp_cmd_t cmd_new;
  assign cmd_new.write = sr_q[SDP_RW_POS];
  assign cmd_new.addr = sr_q[SDP_ADDR_MSB:SDP_ADDR_LSB];
  assign cmd_new.data = sr_q[SDP_DATA_BITS-1:0];

  // next values of the shift path
  always_comb
  begin
    sr_d = sr_q;
    cnt_d = cnt_q;
    tx_d = tx_q;
    sdo_d = sdo_q;
    if (cs_fall)
    begin
      tx_d = {status_events, reply_q};
      cnt_d = 6'h00;
      sdo_d = status_events[7];
    end
    else if (sel_act && sck_rise)
    begin
      // window keeps only last 40 bits
      sr_d = {sr_q[38:0], sdi_s2_q};
      // tx pipe refills with the input bit
      // so it reaches the output exactly 40 clocks later
      tx_d = {tx_q[38:0], sdi_s2_q};
      if (!cnt_full)
        cnt_d = cnt_q + 6'h01;
    end
    else if (sel_act && sck_fall)
    begin
      sdo_d = tx_q[39];
    end
  end

  // reply word for the next datagram
  always_comb
  begin
    reply_d = reply_q;
    if (read_data_valid)
      reply_d = read_data;
    else if (frame_ok && cmd_new.write)
      reply_d = cmd_new.data;
  end

  // shift path registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sr_q <= SDP_SR_RST;
      cnt_q <= 6'h00;
      tx_q <= SDP_SR_RST;
      sdo_q <= 1'b0;
      reply_q <= SDP_DATA_RST;
    end
    else
    begin
      sr_q <= sr_d;
      cnt_q <= cnt_d;
      tx_q <= tx_d;
      sdo_q <= sdo_d;
      reply_q <= reply_d;
    end
  end

  // short frames never reach the buffer
  wire push = frame_ok;
  logic buf_ready;

  // two-entry buffer so a stalled register file loses no command until both entries are held
  sdp_cmd_buf u_buf (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data(cmd_new),
    .out_valid(cmd_valid),
    .out_ready(cmd_ready),
    .out_data(cmd_out)
  );

  // overrun is sticky; the pin has no clear so only reset ends it
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ovr_q <= 1'b0;
      short_q <= 1'b0;
    end
    else
    begin
      if (push && !buf_ready)
        ovr_q <= 1'b1;
      short_q <= frame_short;
    end
  end

  assign host_serial_out = sdo_q;
  assign cmd_overrun = ovr_q;
  assign short_frame = short_q;
endmodule
`default_nettype wire

// File: test/sdp_port_asserts.sv
// checker of the serial datagram port outputs
`timescale 1ns/10ps
`default_nettype none
module sdp_port_asserts
  import sdp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic host_select_n,
  input wire logic host_serial_clock,
  input wire logic host_serial_out,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire sdp_cmd_t cmd_out,
  input wire logic cmd_overrun,
  input wire logic short_frame
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_stall; cmd_valid && !cmd_ready; endsequence
  property p_hold; s_stall |=> cmd_valid && $stable(cmd_out); endproperty
  a_hold: assert property (p_hold) else $error("stall");
  property p_cmdsel; $rose(cmd_valid) |-> host_select_n; endproperty
  a_cmdsel: assert property (p_cmdsel) else $error("early");
  property p_nocmd; short_frame |=> !$rose(cmd_valid); endproperty
  a_nocmd: assert property (p_nocmd) else $error("short cmd");
  property p_pulse; short_frame |=> !short_frame; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse");
  property p_shsel; short_frame |-> host_select_n; endproperty
  a_shsel: assert property (p_shsel) else $error("short");
  property p_stick; cmd_overrun |=> cmd_overrun; endproperty
  a_stick: assert property (p_stick) else $error("sticky");
  property p_full; $rose(cmd_overrun) |-> cmd_valid; endproperty
  a_full: assert property (p_full) else $error("full");
  property p_sdo;
    $rose(host_serial_clock) && !host_select_n |=> $stable(host_serial_out)[*5];
  endproperty
  a_sdo: assert property (p_sdo) else $error("sdo");
endmodule
bind sdp_port sdp_port_asserts u_sdp_port_asserts (.*);
`default_nettype wire

// File: test/sdp_host_model.sv
// host master model clocking datagrams into the port
`timescale 1ns/10ps
`default_nettype none
module sdp_host_model (
  input wire logic ref_clk,
  output logic host_select_n,
  output logic host_serial_clock,
  output logic host_serial_in,
  input wire logic host_serial_out
);
  initial
  begin
    host_select_n = 1'b1;
    host_serial_clock = 1'b0;
    host_serial_in = 1'b0;
  end
  // n bits msb first, reply bit taken at each rise
  task automatic send(input logic [47:0] w, input int n,
    output logic [47:0] rx);
    rx = '0;
    host_select_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      host_serial_in <= w[i];
      repeat (8) @(posedge ref_clk);
      host_serial_clock <= 1'b1;
      rx = {rx[46:0], host_serial_out};
      repeat (8) @(posedge ref_clk);
      host_serial_clock <= 1'b0;
    end
    repeat (8) @(posedge ref_clk);
    host_select_n <= 1'b1;
    // released line shows no stale bit
    host_serial_in <= ~host_serial_in;
    repeat (16) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// File: test/sdp_port_tb.sv
// self-checking bench of the serial datagram port
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module sdp_port_tb
  import sdp_pkg::*;
;
  logic ref_clk, arst_n, host_select_n, host_serial_clock, host_serial_in;
  logic host_serial_out, cmd_valid, cmd_ready, read_data_valid;
  logic cmd_overrun, short_frame;
  logic [7:0] status_events;
  logic [31:0] read_data, d1, d2, rd;
  logic [47:0] rx;
  sdp_cmd_t cmd_out, exp_c;
  sdp_cmd_t exp_q[$];
  int num_errors, checks, shorts;
  sdp_port u_sdp_port (.*);
  sdp_host_model u_sdp_host_model (.*);
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // consumer: oldest note against each taken command
  always @(posedge ref_clk)
  begin
    read_data_valid <= 1'b0;
    if (short_frame === 1'b1) shorts++;
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
    begin
      `CHK(exp_q.size() > 0, 1'b1)
      if (exp_q.size() > 0)
      begin
        exp_c = exp_q.pop_front();
        `CHK(cmd_out, exp_c)
      end
      read_data_valid <= !cmd_out.write;
    end
  end
  // one datagram with random status, reply checked when at least 40 bits
  task automatic frame(input logic [47:0] w, input int n,
    input logic [31:0] rep, input logic keep);
    logic [7:0] st;
    st = 8'($urandom);
    status_events <= st;
    if (keep) exp_q.push_back(sdp_cmd_t'(w[39:0]));
    u_sdp_host_model.send(w, n, rx);
    `CHK(rx[n-1 -: 8], st)
    if (n >= 40) `CHK(rx[n-9 -: 32], rep)
    if (n > 40) `CHK(rx[7:0], w[47:40])
  endtask
  initial
  begin
    void'($urandom(32'hbe85bb29));
    arst_n = 1'b0;
    cmd_ready = 1'b1;
    status_events = 8'h00;
    read_data_valid = 1'b0;
    d1 = $urandom;
    d2 = $urandom;
    rd = $urandom;
    read_data = rd;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    frame({9'h001, 7'h15, d1}, 40, SDP_DATA_RST, 1'b1);
    frame({9'h000, 7'h33, d2}, 40, d1, 1'b1);
    frame({9'h000, 7'h00, d1}, 8, d1, 1'b0);
    cmd_ready <= 1'b0;
    frame({9'h0a5, 7'h11, d2}, 48, rd, 1'b1);
    frame({9'h001, 7'h12, d1}, 39, d1, 1'b0);
    frame({9'h001, 7'h22, d1}, 40, d2, 1'b1);
    frame({9'h001, 7'h23, rd}, 40, d1, 1'b0);
    `CHK(cmd_overrun, 1'b1)
    `CHK(shorts, 2)
    cmd_ready <= 1'b1;
    repeat (8) @(posedge ref_clk);
    `CHK(exp_q.size(), 0)
    results;
  end
  initial
  begin
    #200000;
    num_errors++;
    results;
  end
  task automatic results;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
endmodule
`default_nettype wire
